// ==== hw/pll_ctl_cfg.svh ====
`ifndef PLL_CTL_CFG_SVH
`define PLL_CTL_CFG_SVH

// Register byte addresses (word aligned)
`define CTRL_ADDR 4'h0
`define BW_ADDR 4'h4
`define MODE_ADDR 4'h8

// Control register fields
`define CTRL_INT_EN 7
`define CTRL_INT_FLAG 6
`define CTRL_POWER 5
`define CTRL_BCS 4
// Bandwidth register fields
`define BW_AUTO 7
`define BW_LOCK 6
`define BW_ACQ 5
// Mode register fields
`define MODE_BREAK_CLR 0

`define CTRL_LOW_NIBBLE 4'hF
`define RESET_POWER 1'b1

// Acquisition and lock qualification times, in nanoseconds, converted to clock cycles
`define ACQ_TIME_NS 640
`define LOCK_TIME_NS 1280
`define CLK_PERIOD_NS 10
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_CYCLES ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hw/pll_ctl_pkg.sv ====
package pll_ctl_pkg;
  typedef enum logic [1:0] {
    LOOP_OFF = 2'b00,
    LOOP_ACQ = 2'b01,
    LOOP_TRK = 2'b11,
    LOOP_LCK = 2'b10
  } loop_state_type;
endpackage

// ==== hw/loop_if.sv ====
`timescale 1ns/100ps
interface loop_if;
  logic power;
  logic auto_mode;
  logic stop;
  logic freq_ok;
  logic tracking;
  logic locked;
  modport ctl (output power, output auto_mode, output stop, output freq_ok,
    input tracking, input locked);
  modport seq (input power, input auto_mode, input stop, input freq_ok,
    output tracking, output locked);
endinterface

// ==== hw/lock_sequencer.sv ====
`timescale 1ns/100ps
`include "pll_ctl_cfg.svh"
module lock_sequencer
  import pll_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  loop_if.seq lp
);
  localparam logic [7:0] ACQ_N = 8'(`ACQ_CYCLES);
  localparam logic [7:0] LOCK_N = 8'(`LOCK_CYCLES);
  loop_state_type state_q;
  loop_state_type state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire run = lp.power && lp.auto_mode && !lp.stop;
  wire ok = lp.freq_ok;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 8'h01;
    case (state_q)
      LOOP_OFF: begin
        cnt_d = 8'h00;
        if (run) state_d = LOOP_ACQ;
      end
      LOOP_ACQ: begin
        if (!ok) cnt_d = 8'h00;
        else if (cnt_q == ACQ_N - 8'h01) begin
          state_d = LOOP_TRK;
          cnt_d = 8'h00;
        end
      end
      LOOP_TRK: begin
        if (!ok) begin
          state_d = LOOP_ACQ;
          cnt_d = 8'h00;
        end else if (cnt_q == LOCK_N - 8'h01) begin
          state_d = LOOP_LCK;
          cnt_d = 8'h00;
        end
      end
      LOOP_LCK: begin
        cnt_d = 8'h00;
        if (!ok) state_d = LOOP_ACQ;
      end
      default: state_d = LOOP_OFF;
    endcase
    if (!run) begin
      state_d = LOOP_OFF;
      cnt_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= LOOP_OFF;
      cnt_q <= 8'h00;
    end else if (ce_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Tracking sets when acquisition completes; lock when lock time expires
  assign lp.tracking = (state_q == LOOP_TRK) || (state_q == LOOP_LCK);
  assign lp.locked = (state_q == LOOP_LCK);
endmodule

// ==== hw/pll_lock_interrupt_and_mode_ctl.sv ====
// Operation
// - Auto mode: lock change raises interrupt condition
// - Interrupt reaches CPU only if enabled
// - Flag sets regardless of interrupt enable
// - Manual mode: no interrupts, flag reads zero
// - Base select sources output from VCO/2
// - Base select allowed while unlocked
// - Wait mode leaves block unchanged
// - Stop disables core, core enable and base clock outputs low
// - Break clear enable permits clearing in break
// - Flag cleared in break stays cleared
// - Break clear disabled: flag untouched in break
// - Tracking bit sets when acquisition completes
// - Lock bit sets when lock time expires
// - Control register read clears flag
// - Base select ignored while power off
// - Output is half selected source frequency
// - Lock read-only, set at programmed frequency
`timescale 1ns/100ps
`include "pll_ctl_cfg.svh"
module pll_lock_interrupt_and_mode_ctl
  import pll_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic crystal_clock_i,
  input wire logic vco_clock_i,
  input wire logic vco_freq_ok_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic break_state_i,
  output logic base_clock_out_o,
  output logic pll_irq_o,
  output logic core_enable_o
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic int_en_q;
  logic int_flag_q;
  logic power_q;
  logic bcs_q;
  logic auto_q;
  logic acq_man_q;
  logic break_clr_q;
  logic lock_prev_q;
  logic xdiv_q;
  logic vdiv_q;
  logic xtal_prev_q;
  logic vco_prev_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic irq_q;
  logic base_q;
  logic core_q;
  loop_if lp ();

  lock_sequencer u_seq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .lp(lp)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire sel0 = wb_sel_i[0];
  wire hit_ctrl = wb_adr_i == `CTRL_ADDR;
  wire hit_bw = wb_adr_i == `BW_ADDR;
  wire hit_mode = wb_adr_i == `MODE_ADDR;
  wire wr_ctrl = req && wb_we_i && sel0 && hit_ctrl;
  wire wr_bw = req && wb_we_i && sel0 && hit_bw;
  wire wr_mode = req && wb_we_i && sel0 && hit_mode;
  // Only a read access to the control register counts as a read; writes do not
  wire rd_ctrl = req && hit_ctrl && !wb_we_i;
  wire lock = lp.locked && auto_q;
  wire tracking = auto_q ? lp.tracking : acq_man_q;
  // Interrupt condition on every lock toggle, auto mode only
  wire lock_evt = auto_q && (lp.locked != lock_prev_q);
  wire clear_ok = !break_state_i || break_clr_q;
  wire flag_clr = rd_ctrl && clear_ok;
  wire flag_vis = int_flag_q && auto_q;
  wire [7:0] ctrl_rd = {int_en_q && auto_q, flag_vis, power_q, bcs_q, `CTRL_LOW_NIBBLE};
  wire [7:0] bw_rd = {auto_q, lock, tracking, 5'h00};
  wire [7:0] mode_rd = {7'h00, break_clr_q};
  wire [7:0] rd_mux = hit_ctrl ? ctrl_rd : hit_bw ? bw_rd : hit_mode ? mode_rd : 8'h00;
  // Power off blocks base select; base select set keeps power on, but one write that sets base select and clears power does both
  wire bcs_wr = wb_dat_i[`CTRL_BCS] && (power_q || bcs_q);
  wire pwr_wr = wb_dat_i[`CTRL_POWER] || bcs_q;

  assign lp.power = power_q;
  assign lp.auto_mode = auto_q;
  assign lp.stop = stop_mode_i;
  assign lp.freq_ok = vco_freq_ok_i;

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  // Wait mode is deliberately not an input to any state here
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_en_q <= 1'b0;
      power_q <= `RESET_POWER;
      bcs_q <= 1'b0;
      auto_q <= 1'b0;
      acq_man_q <= 1'b0;
      break_clr_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        if (auto_q) int_en_q <= wb_dat_i[`CTRL_INT_EN];
        power_q <= pwr_wr;
        bcs_q <= bcs_wr;
      end
      if (wr_bw) begin
        auto_q <= wb_dat_i[`BW_AUTO];
        if (!auto_q) acq_man_q <= wb_dat_i[`BW_ACQ];
      end
      if (wr_mode) break_clr_q <= wb_dat_i[`MODE_BREAK_CLR];
    end
  end

  // Flag: a lock event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_flag_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else if (ce_i) begin
      lock_prev_q <= lp.locked;
      if (lock_evt) int_flag_q <= 1'b1;
      else if (flag_clr) int_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bus answer: one wait state, ack for one cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (ce_i) begin
      ack_q <= req;
      if (req) rdata_q <= {24'h000000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Base clock: sources sampled as data, so each divides by two at
  // most at half the bus rate; a real part uses a glitch-free mux
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xtal_prev_q <= 1'b0;
      vco_prev_q <= 1'b0;
      xdiv_q <= 1'b0;
      vdiv_q <= 1'b0;
      base_q <= 1'b0;
      core_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce_i) begin
      xtal_prev_q <= crystal_clock_i;
      vco_prev_q <= vco_clock_i;
      if (crystal_clock_i && !xtal_prev_q) xdiv_q <= !xdiv_q;
      if (vco_clock_i && !vco_prev_q) vdiv_q <= !vdiv_q;
      base_q <= !stop_mode_i && (bcs_q ? vdiv_q : xdiv_q);
      core_q <= power_q && !stop_mode_i;
      // A lock event in the clearing cycle keeps the flag, so irq must stay up too
      irq_q <= flag_vis && int_en_q && auto_q && !(flag_clr && !lock_evt);
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign base_clock_out_o = base_q;
  assign pll_irq_o = irq_q;
  assign core_enable_o = core_q;
endmodule

// ==== bench/sys_side_model.sv ====
`timescale 1ns/100ps
// ------
// Source clocks and interrupt sink
// ------
module sys_side_model (
  input wire logic clk_i,
  input wire logic irq_i,
  output logic xtal_o,
  output logic vco_o,
  output int irq_count_o
);
  // Sources stay under clk/2 because the block samples them as data
  logic [2:0] div_q = 3'h0;
  logic irq_q = 1'b0;
  initial irq_count_o = 0;
  always @(posedge clk_i) begin
    div_q <= div_q + 3'h1;
    irq_q <= irq_i;
    if (irq_i === 1'b1 && irq_q === 1'b0) irq_count_o <= irq_count_o + 1;
  end
  assign xtal_o = div_q[2];
  assign vco_o = div_q[1];
endmodule

// ==== bench/pll_ctl_properties.sv ====
`timescale 1ns/100ps
module pll_ctl_properties (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input wire logic stop_mode_i,
  input logic base_clock_out_o,
  input logic pll_irq_o,
  input logic core_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire rd_ctrl = req && !wb_we_i && wb_adr_i == 4'h0;
  a_ack_answer: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  a_ctrl_ones: assert property (rd_ctrl |=> wb_dat_o[3:0] == 4'hF) else $error("low bits");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 4'hC |=> wb_dat_o == 32'h0)
    else $error("unmapped");
  a_stop_core: assert property (stop_mode_i && ce_i |=> !core_enable_o)
    else $error("core on in stop");
  a_stop_base: assert property (stop_mode_i && ce_i |=> !base_clock_out_o)
    else $error("base in stop");
  cover property (rd_ctrl && pll_irq_o);
  cover property ($rose(pll_irq_o));
  cover property (stop_mode_i && core_enable_o);
endmodule
bind pll_lock_interrupt_and_mode_ctl pll_ctl_properties u_props (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .stop_mode_i(stop_mode_i), .base_clock_out_o(base_clock_out_o),
  .pll_irq_o(pll_irq_o), .core_enable_o(core_enable_o));

// ==== bench/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fok = 1'b1, wt = 1'b0, stp = 1'b0, brk = 1'b0, ce = 1'b1;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, wdo, rdat;
  logic ack, base, irq, core, xtal, vco;
  int irqn, n_errors = 0, check_count = 0;
  logic [7:0] wr_t [6] = '{8'h30, 8'h10, 8'h20, 8'h00, 8'h10, 8'h20};
  logic [7:0] ex_t [6] = '{8'h3F, 8'h3F, 8'h2F, 8'h0F, 8'h0F, 8'h2F};
  always #5 clk_i = ~clk_i;
  pll_lock_interrupt_and_mode_ctl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .crystal_clock_i(xtal),
    .vco_clock_i(vco), .vco_freq_ok_i(fok), .wait_mode_i(wt), .stop_mode_i(stp),
    .break_state_i(brk), .base_clock_out_o(base), .pll_irq_o(irq), .core_enable_o(core));
  sys_side_model far (.clk_i(clk_i), .irq_i(irq), .xtal_o(xtal), .vco_o(vco),
    .irq_count_o(irqn));
  // ------
  // Bus access and compare
  // ------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = wdo;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask
  task bcount(input int e);
    int c;
    logic p;
    c = 0;
    repeat (16) @(posedge clk_i);
    p = base;
    repeat (64) begin
      @(posedge clk_i);
      if (base === 1'b1 && p === 1'b0) c++;
      p = base;
    end
    chk("base rises", e, c);
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Whole run is about 1400 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    acc(1'b1, 4'h0, 8'hA0);
    rd(4'h0, 8'h2F, "ctrl manual");
    chk("irq", 1'h0, irq);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 4'h0, wr_t[i]);
      rd(4'h0, ex_t[i], "ctrl sel");
      bcount(wr_t[i][4] && ex_t[i][4] ? 8 : 4);
    end
    acc(1'b1, 4'h4, 8'h80);
    repeat (70) @(posedge clk_i);
    rd(4'h4, 8'hA0, "bw track");
    wt <= 1'b1;
    repeat (140) @(posedge clk_i);
    rd(4'h4, 8'hE0, "bw lock");
    wt <= 1'b0;
    rd(4'h0, 8'h6F, "ctrl flag");
    chk("irq masked", 0, irqn);
    rd(4'h0, 8'h2F, "ctrl cleared");
    acc(1'b1, 4'h0, 8'hA0);
    fok <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk("irq on", 1'h1, irq);
    rd(4'h4, 8'h80, "bw unlock");
    rd(4'h0, 8'hEF, "ctrl loss");
    chk("irq off", 1'h0, irq);
    fok <= 1'b1;
    repeat (210) @(posedge clk_i);
    brk <= 1'b1;
    rd(4'h0, 8'hEF, "brk read");
    rd(4'h0, 8'hEF, "brk kept");
    acc(1'b1, 4'h8, 8'h01);
    rd(4'h0, 8'hEF, "brk clr");
    rd(4'h0, 8'hAF, "brk cleared");
    brk <= 1'b0;
    rd(4'h0, 8'hAF, "after brk");
    acc(1'b1, 4'hC, 8'hFF);
    rd(4'hC, 8'h00, "unmapped");
    stp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("core stop", 1'h0, core);
    bcount(0);
    stp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("core run", 1'h1, core);
    // Clock enable low must freeze the core enable even as stop rises
    ce <= 1'b0;
    stp <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("core frozen", 1'h1, core);
    stp <= 1'b0;
    ce <= 1'b1;
    repeat (210) @(posedge clk_i);
    rd(4'h4, 8'hE0, "bw relock");
    acc(1'b1, 4'h0, 8'hB0);
    rd(4'h0, 8'hFF, "ctrl vco");
    bcount(8);
    acc(1'b1, 4'h0, 8'hA0);
    acc(1'b1, 4'h0, 8'h80);
    wt <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h0, 8'hCF, "ctrl off");
    chk("core off", 1'h0, core);
    wt <= 1'b0;
    summarize();
  end
endmodule
